// File: rtl/mrd_pkg.sv
// constants and register map of the region descriptor register block
// Function
// - Lower descriptor accesses go to the region named by the selector.
// - Lower bound is field bits 31..5 with bits 4..0 zero.
// - Sharing 00 is none, 10 outer, 11 inner, 01 unpredictable.
// - Sharing is ignored when the region's memory is device memory.
// - Permission 00 is privileged read/write, 01 any read/write.
// - Permission 10 is privileged read only, 11 any read only.
// - Execute-never set forbids fetch; clear allows fetch where readable.
// - Alias view n targets region {selector[7:2], n} in the same bank.
// - Upper bound is field bits 31..5 with bits 4..0 ones.
// - The 3-bit attribute selector picks one of eight attribute bytes.
// - A region takes part in checking only when its enable bit is 1.
// - Each security state has its own copy of both descriptors.
// - Attribute byte n sits at bits 8n+7..8n of the attribute tables.
// - An access that breaks the matching region's permissions faults.
package mrd_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_SEL = 8'h00;
  localparam logic [7:0] OFF_LOWER = 8'h04;
  localparam logic [7:0] OFF_UPPER = 8'h08;
  localparam logic [7:0] OFF_LOWER_A1 = 8'h0C;
  localparam logic [7:0] OFF_UPPER_A1 = 8'h10;
  localparam logic [7:0] OFF_LOWER_A2 = 8'h14;
  localparam logic [7:0] OFF_UPPER_A2 = 8'h18;
  localparam logic [7:0] OFF_LOWER_A3 = 8'h1C;
  localparam logic [7:0] OFF_UPPER_A3 = 8'h20;
  localparam logic [7:0] OFF_ATTR_LO = 8'h24;
  localparam logic [7:0] OFF_ATTR_HI = 8'h28;
  localparam logic [7:0] OFF_INT_STAT = 8'h2C;
  localparam logic [7:0] OFF_INT_MASK = 8'h30;
  localparam logic [7:0] OFF_FAULT_ADDR = 8'h34;
  // descriptor fields
  localparam int BOUND_LSB = 5;
  localparam int SH_LSB = 3;
  localparam int AP_LSB = 1;
  localparam int XN_BIT = 0;
  localparam int ATTR_SEL_LSB = 1;
  localparam int EN_BIT = 0;
  localparam logic [31:0] UPPER_WR_MASK = 32'hFFFF_FFEF;
  localparam logic [4:0] LOW_ZERO = 5'h00;
  localparam logic [4:0] LOW_ONES = 5'h1F;
  // sharing codes
  localparam logic [1:0] SH_NONE = 2'h0;
  localparam logic [1:0] SH_BAD = 2'h1;
  localparam logic [1:0] SH_OUTER = 2'h2;
  localparam logic [1:0] SH_INNER = 2'h3;
  localparam logic [3:0] ATTR_DEVICE_HI = 4'h0;
  // interrupt status bits
  localparam int INT_W = 2;
  localparam int INT_FAULT = 0;
  localparam int INT_MISS = 1;
  // reset values
  localparam logic [31:0] DESC_RST = 32'h0000_0000;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [31:0] ATTR_RST = 32'h0000_0000;
  localparam logic [INT_W-1:0] INT_RST = 2'h0;
  localparam int NUM_REGIONS_DEF = 8;
endpackage

// File: rtl/mrd_perm_check.sv
// permission and execute-never check for one matched region
`timescale 1ns/100ps
module mrd_perm_check (
  input wire logic [1:0] ap_i,
  input wire logic xn_i,
  input wire logic priv_i,
  input wire logic write_i,
  input wire logic fetch_i,
  output logic allow_o
);
  logic read_ok;
  logic write_ok;
  logic exec_ok;
  assign read_ok = priv_i | ap_i[0];
  assign write_ok = ~ap_i[1] & read_ok;
  assign exec_ok = ~xn_i & read_ok;
  assign allow_o = fetch_i ? exec_ok : (write_i ? write_ok : read_ok);
endmodule

// File: rtl/mrd_attr_decode.sv
// attribute byte pick and sharing decode for one matched region
`timescale 1ns/100ps
module mrd_attr_decode (
  input wire logic [31:0] table_lo_i,
  input wire logic [31:0] table_hi_i,
  input wire logic [2:0] attr_sel_i,
  input wire logic [1:0] sh_i,
  output logic [7:0] attr_o,
  output logic device_o,
  output logic [1:0] share_o
);
  logic [63:0] table_all;
  logic [1:0] share_norm;
  assign table_all = {table_hi_i, table_lo_i};
  assign attr_o = table_all[{attr_sel_i, 3'h0} +: 8];
  assign device_o = (attr_o[7:4] == mrd_pkg::ATTR_DEVICE_HI);
  // unpredictable code treated as non-shareable
  assign share_norm = (sh_i == mrd_pkg::SH_BAD) ? mrd_pkg::SH_NONE
                      : sh_i;
  assign share_o = device_o ? mrd_pkg::SH_NONE : share_norm;
endmodule

// File: rtl/mrd_regs.sv
// region descriptor registers, banked per security state, with check port
`timescale 1ns/100ps
module mrd_regs #(
  parameter int NUM_REGIONS = mrd_pkg::NUM_REGIONS_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic REG_SEC_I,
  output logic [31:0] REG_RDATA_O,
  input wire logic CHK_VALID_I,
  input wire logic [31:0] CHK_ADDR_I,
  input wire logic CHK_WRITE_I,
  input wire logic CHK_FETCH_I,
  input wire logic CHK_PRIV_I,
  input wire logic CHK_SEC_I,
  output logic CHK_DONE_O,
  output logic CHK_HIT_O,
  output logic [7:0] CHK_REGION_O,
  output logic CHK_FAULT_O,
  output logic [7:0] CHK_ATTR_O,
  output logic [1:0] CHK_SHARE_O,
  output logic CHK_DEVICE_O,
  output logic IRQ_O
);
  localparam int RIW = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;

  if (NUM_REGIONS < 1 || NUM_REGIONS > 256) begin : g_bad_count
    $error("NUM_REGIONS must lie in 1..256");
  end

  // region targeted by view 0 (direct) or alias view 1..3
  function automatic logic [7:0] view_region(input logic [7:0] sel,
                                             input logic [1:0] view);
    if (view == 2'h0) begin
      return sel;
    end
    return {sel[7:2], view};
  endfunction

  function automatic logic region_ok(input logic [7:0] idx);
    return {1'b0, idx} < 9'(NUM_REGIONS);
  endfunction

  // storage, descriptors, selector and attribute tables banked per security state
  logic [31:0] lower_q [2][NUM_REGIONS];
  logic [31:0] upper_q [2][NUM_REGIONS];
  logic [7:0] sel_q [2];
  logic [31:0] attr_lo_q [2];
  logic [31:0] attr_hi_q [2];
  logic [mrd_pkg::INT_W-1:0] stat_q;
  logic [mrd_pkg::INT_W-1:0] stat_d;
  logic [mrd_pkg::INT_W-1:0] mask_q;
  logic [31:0] fault_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // register decode
  wire logic bank = REG_SEC_I;
  wire logic hit_sel = REG_ADDR_I == mrd_pkg::OFF_SEL;
  wire logic hit_l0 = REG_ADDR_I == mrd_pkg::OFF_LOWER;
  wire logic hit_u0 = REG_ADDR_I == mrd_pkg::OFF_UPPER;
  wire logic hit_l1 = REG_ADDR_I == mrd_pkg::OFF_LOWER_A1;
  wire logic hit_u1 = REG_ADDR_I == mrd_pkg::OFF_UPPER_A1;
  wire logic hit_l2 = REG_ADDR_I == mrd_pkg::OFF_LOWER_A2;
  wire logic hit_u2 = REG_ADDR_I == mrd_pkg::OFF_UPPER_A2;
  wire logic hit_l3 = REG_ADDR_I == mrd_pkg::OFF_LOWER_A3;
  wire logic hit_u3 = REG_ADDR_I == mrd_pkg::OFF_UPPER_A3;
  wire logic hit_alo = REG_ADDR_I == mrd_pkg::OFF_ATTR_LO;
  wire logic hit_ahi = REG_ADDR_I == mrd_pkg::OFF_ATTR_HI;
  wire logic hit_ist = REG_ADDR_I == mrd_pkg::OFF_INT_STAT;
  wire logic hit_imk = REG_ADDR_I == mrd_pkg::OFF_INT_MASK;
  wire logic hit_fad = REG_ADDR_I == mrd_pkg::OFF_FAULT_ADDR;
  wire logic hit_lower = hit_l0 | hit_l1 | hit_l2 | hit_l3;
  wire logic hit_upper = hit_u0 | hit_u1 | hit_u2 | hit_u3;
  wire logic [1:0] view = (hit_l1 | hit_u1) ? 2'h1 :
                          (hit_l2 | hit_u2) ? 2'h2 :
                          (hit_l3 | hit_u3) ? 2'h3 : 2'h0;
  wire logic [7:0] tgt = view_region(sel_q[bank], view);
  wire logic tgt_ok = region_ok(tgt);
  wire logic [RIW-1:0] tgt_i = tgt[RIW-1:0];
  wire logic wr_lower = REG_WR_I & hit_lower & tgt_ok;
  wire logic wr_upper = REG_WR_I & hit_upper & tgt_ok;
  wire logic [31:0] rd_lower = tgt_ok ? lower_q[bank][tgt_i] : 32'h0;
  wire logic [31:0] rd_upper = tgt_ok ? upper_q[bank][tgt_i] : 32'h0;
  wire logic [31:0] rd_sel = {24'h00_0000, sel_q[bank]};
  wire logic [31:0] rd_stat = {{(32-mrd_pkg::INT_W){1'b0}}, stat_q};
  wire logic [31:0] rd_mask = {{(32-mrd_pkg::INT_W){1'b0}}, mask_q};
  wire logic wr_sel = REG_WR_I & hit_sel;
  wire logic wr_alo = REG_WR_I & hit_alo;
  wire logic wr_ahi = REG_WR_I & hit_ahi;
  wire logic wr_stat = REG_WR_I & hit_ist;
  wire logic wr_mask = REG_WR_I & hit_imk;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_sel) begin
      rdata_d = rd_sel;
    end else if (hit_lower) begin
      rdata_d = rd_lower;
    end else if (hit_upper) begin
      rdata_d = rd_upper & mrd_pkg::UPPER_WR_MASK;
    end else if (hit_alo) begin
      rdata_d = attr_lo_q[bank];
    end else if (hit_ahi) begin
      rdata_d = attr_hi_q[bank];
    end else if (hit_ist) begin
      rdata_d = rd_stat;
    end else if (hit_imk) begin
      rdata_d = rd_mask;
    end else if (hit_fad) begin
      rdata_d = fault_addr_q;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (REG_RD_I) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign REG_RDATA_O = rdata_q;

  // descriptor storage writes
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int b = 0; b < 2; b++) begin
        for (int r = 0; r < NUM_REGIONS; r++) begin
          lower_q[b][r] <= mrd_pkg::DESC_RST;
          upper_q[b][r] <= mrd_pkg::DESC_RST;
        end
      end
    end else begin
      if (wr_lower) begin
        lower_q[bank][tgt_i] <= REG_WDATA_I;
      end
      if (wr_upper) begin
        upper_q[bank][tgt_i] <= REG_WDATA_I & mrd_pkg::UPPER_WR_MASK;
      end
    end
  end

  // selector, banked like the descriptors
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int b = 0; b < 2; b++) begin
        sel_q[b] <= mrd_pkg::SEL_RST;
      end
    end else if (wr_sel) begin
      sel_q[bank] <= REG_WDATA_I[7:0];
    end
  end

  // attribute tables, eight bytes per bank
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int b = 0; b < 2; b++) begin
        attr_lo_q[b] <= mrd_pkg::ATTR_RST;
        attr_hi_q[b] <= mrd_pkg::ATTR_RST;
      end
    end else begin
      if (wr_alo) begin
        attr_lo_q[bank] <= REG_WDATA_I;
      end
      if (wr_ahi) begin
        attr_hi_q[bank] <= REG_WDATA_I;
      end
    end
  end

  // region search over the bank of the access
  logic srch_hit;
  logic [7:0] srch_idx;
  logic [31:0] lo_addr;
  logic [31:0] hi_addr;
  wire logic cb = CHK_SEC_I;

  always_comb begin
    srch_hit = 1'b0;
    srch_idx = 8'h00;
    lo_addr = 32'h0000_0000;
    hi_addr = 32'h0000_0000;
    // highest numbered match wins
    for (int r = 0; r < NUM_REGIONS; r++) begin
      lo_addr = {lower_q[cb][r][31:mrd_pkg::BOUND_LSB],
                 mrd_pkg::LOW_ZERO};
      hi_addr = {upper_q[cb][r][31:mrd_pkg::BOUND_LSB],
                 mrd_pkg::LOW_ONES};
      if (upper_q[cb][r][mrd_pkg::EN_BIT] &&
          CHK_ADDR_I >= lo_addr && CHK_ADDR_I <= hi_addr) begin
        srch_hit = 1'b1;
        srch_idx = 8'(r);
      end
    end
  end

  wire logic [RIW-1:0] m_i = srch_idx[RIW-1:0];
  wire logic [31:0] m_lower = lower_q[cb][m_i];
  wire logic [31:0] m_upper = upper_q[cb][m_i];
  logic allow;
  logic [7:0] m_attr;
  logic m_device;
  logic [1:0] m_share;

  mrd_perm_check u_perm (
    .ap_i(m_lower[mrd_pkg::AP_LSB +: 2]),
    .xn_i(m_lower[mrd_pkg::XN_BIT]),
    .priv_i(CHK_PRIV_I),
    .write_i(CHK_WRITE_I),
    .fetch_i(CHK_FETCH_I),
    .allow_o(allow)
  );

  mrd_attr_decode u_attr (
    .table_lo_i(attr_lo_q[cb]),
    .table_hi_i(attr_hi_q[cb]),
    .attr_sel_i(m_upper[mrd_pkg::ATTR_SEL_LSB +: 3]),
    .sh_i(m_lower[mrd_pkg::SH_LSB +: 2]),
    .attr_o(m_attr),
    .device_o(m_device),
    .share_o(m_share)
  );

  wire logic ev_fault = CHK_VALID_I & srch_hit & ~allow;
  wire logic ev_miss = CHK_VALID_I & ~srch_hit;

  // check results, registered one cycle after the request
  logic done_q;
  logic hit_q;
  logic fault_q;
  logic dev_q;
  logic [7:0] reg_q;
  logic [7:0] attr_q;
  logic [1:0] share_q;

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      done_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      done_q <= CHK_VALID_I;
      fault_q <= ev_fault;
    end
  end

  // results hold until the next request
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      hit_q <= 1'b0;
      dev_q <= 1'b0;
      reg_q <= 8'h00;
      attr_q <= 8'h00;
      share_q <= 2'h0;
    end else if (CHK_VALID_I) begin
      hit_q <= srch_hit;
      dev_q <= srch_hit & m_device;
      reg_q <= srch_idx;
      attr_q <= srch_hit ? m_attr : 8'h00;
      share_q <= srch_hit ? m_share : 2'h0;
    end
  end

  assign CHK_DONE_O = done_q;
  assign CHK_HIT_O = hit_q;
  assign CHK_FAULT_O = fault_q;
  assign CHK_DEVICE_O = dev_q;
  assign CHK_REGION_O = reg_q;
  assign CHK_ATTR_O = attr_q;
  assign CHK_SHARE_O = share_q;

  // sticky status, set wins over write-one clear
  wire logic [mrd_pkg::INT_W-1:0] ev_set = {ev_miss, ev_fault};
  wire logic [mrd_pkg::INT_W-1:0] ev_clr =
    wr_stat ? REG_WDATA_I[mrd_pkg::INT_W-1:0] : '0;
  assign stat_d = (stat_q & ~ev_clr) | ev_set;

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stat_q <= mrd_pkg::INT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mask_q <= mrd_pkg::INT_RST;
    end else if (wr_mask) begin
      mask_q <= REG_WDATA_I[mrd_pkg::INT_W-1:0];
    end
  end

  // last faulting address, overwritten by each new fault
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      fault_addr_q <= 32'h0000_0000;
    end else if (ev_fault) begin
      fault_addr_q <= CHK_ADDR_I;
    end
  end

  assign IRQ_O = |(stat_q & mask_q);
endmodule

// File: tb/mrd_regs_asserts.sv
// port assertions for the region descriptor register block
`timescale 1ns/100ps
module mrd_regs_chk (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic CHK_VALID_I,
  input wire logic CHK_DONE_O,
  input wire logic CHK_HIT_O,
  input wire logic [7:0] CHK_REGION_O,
  input wire logic CHK_FAULT_O,
  input wire logic [7:0] CHK_ATTR_O,
  input wire logic [1:0] CHK_SHARE_O,
  input wire logic CHK_DEVICE_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_done_follows: assert property (CHK_VALID_I |=> CHK_DONE_O)
    else $error("done missing");
  a_done_no_req: assert property (!CHK_VALID_I |=> !CHK_DONE_O)
    else $error("done without request");
  a_fault_on_hit: assert property (CHK_FAULT_O |-> CHK_DONE_O && CHK_HIT_O)
    else $error("fault without hit");
  a_miss_quiet: assert property (CHK_DONE_O && !CHK_HIT_O |->
    !CHK_FAULT_O && CHK_ATTR_O == 8'h00 && CHK_SHARE_O == 2'h0)
    else $error("miss not quiet");
  a_device_flag: assert property (CHK_HIT_O |->
    CHK_DEVICE_O == (CHK_ATTR_O[7:4] == 4'h0))
    else $error("device flag wrong");
  a_device_share: assert property (CHK_DEVICE_O |-> CHK_SHARE_O == 2'h0)
    else $error("device share set");
  a_share_legal: assert property (CHK_SHARE_O != 2'h1)
    else $error("share code 01");
  a_result_hold: assert property (!CHK_VALID_I |=> $stable(CHK_HIT_O) &&
    $stable(CHK_REGION_O) && $stable(CHK_ATTR_O))
    else $error("result moved");
  a_rdata_idle: assert property (!REG_RD_I |=> REG_RDATA_O == 32'h0)
    else $error("read data not idle");
  a_upper_bit4: assert property (REG_RD_I &&
    REG_ADDR_I inside {8'h08, 8'h10, 8'h18, 8'h20} |=> !REG_RDATA_O[4])
    else $error("upper bit 4 set");
  c_fault: cover property (CHK_FAULT_O);
  c_miss: cover property (CHK_DONE_O && !CHK_HIT_O);
  c_device: cover property (CHK_DONE_O && CHK_DEVICE_O);
endmodule
bind mrd_regs mrd_regs_chk u_chk (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .CHK_VALID_I(CHK_VALID_I), .CHK_DONE_O(CHK_DONE_O), .CHK_HIT_O(CHK_HIT_O),
  .CHK_REGION_O(CHK_REGION_O), .CHK_FAULT_O(CHK_FAULT_O),
  .CHK_ATTR_O(CHK_ATTR_O), .CHK_SHARE_O(CHK_SHARE_O),
  .CHK_DEVICE_O(CHK_DEVICE_O));

// File: tb/tb_top.sv
// self-checking bench for the region descriptor register block
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_n, wr, rd, sec, cv, cw, cf, cp, cs;
  logic done, hit, flt, dev, irq;
  logic [7:0] addr, reg_o, attr;
  logic [31:0] wd, ca, rdata;
  logic [1:0] shr, st, mk;
  logic [31:0] lo [2][8];
  logic [31:0] up [2][8];
  logic [31:0] tb [2][2];
  logic [7:0] sl [2];
  logic [31:0] fq [$];
  int n_fail, tests_run;
  int seed = 32'hD233BE9F;
  mrd_regs u_dut (.REF_CLK_I(clk), .RSTN_I(rst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_SEC_I(sec),
    .REG_RDATA_O(rdata), .CHK_VALID_I(cv), .CHK_ADDR_I(ca),
    .CHK_WRITE_I(cw), .CHK_FETCH_I(cf), .CHK_PRIV_I(cp), .CHK_SEC_I(cs),
    .CHK_DONE_O(done), .CHK_HIT_O(hit), .CHK_REGION_O(reg_o),
    .CHK_FAULT_O(flt), .CHK_ATTR_O(attr), .CHK_SHARE_O(shr),
    .CHK_DEVICE_O(dev), .IRQ_O(irq));
  task check(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task conclude();
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // region reached by a descriptor offset, alias views included
  function automatic int rg(logic [7:0] a, logic s);
    logic [7:0] n;
    n = (a - 8'h04) >> 3;
    return (n == 8'h00) ? sl[s] : {sl[s][7:2], n[1:0]};
  endfunction
  function automatic logic [31:0] mrd(logic [7:0] a, logic s);
    int r;
    r = rg(a, s);
    if (a >= 8'h04 && a <= 8'h20)
      return (r > 7) ? 32'h0 : a[2] ? lo[s][r] : up[s][r];
    case (a)
      8'h00: return {24'h0, sl[s]};
      8'h24, 8'h28: return tb[s][a[3]];
      8'h2C: return {30'h0, st};
      8'h30: return {30'h0, mk};
      8'h34: return (fq.size() > 0) ? fq[$] : 32'h0;
      default: return 32'h0;
    endcase
  endfunction
  function automatic void mwr(logic [7:0] a, logic [31:0] d, logic s);
    int r;
    r = rg(a, s);
    if (a >= 8'h04 && a <= 8'h20 && r < 8) begin
      if (a[2]) lo[s][r] = d;
      else up[s][r] = d & 32'hFFFFFFEF;
    end
    case (a)
      8'h00: sl[s] = d[7:0];
      8'h24, 8'h28: tb[s][a[3]] = d;
      8'h2C: st = st & ~d[1:0];
      8'h30: mk = d[1:0];
      default: ;
    endcase
  endfunction
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic s);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    sec <= s;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (w) mwr(a, d, s);
    else check("rdata", rdata, mrd(a, s));
  endtask
  task chk(input logic [31:0] a, input logic w, f, p, s);
    int i, m;
    logic [7:0] b;
    logic ok, r;
    @(posedge clk);
    cv <= 1'b1;
    ca <= a;
    cw <= w;
    cf <= f;
    cp <= p;
    cs <= s;
    @(posedge clk);
    cv <= 1'b0;
    #1;
    m = -1;
    for (i = 0; i < 8; i++)
      if (up[s][i][0] && a >= {lo[s][i][31:5], 5'h00} &&
          a <= {up[s][i][31:5], 5'h1F}) m = i;
    check("done", done, 1'b1);
    check("hit", hit, m >= 0);
    if (m < 0) begin
      st[1] = 1'b1;
      check("fault", flt, 1'b0);
      check("attr", attr, 8'h00);
      check("share", shr, 2'h0);
      check("device", dev, 1'b0);
    end else begin
      r = p | lo[s][m][1];
      ok = f ? (r & ~lo[s][m][0]) : w ? (r & ~lo[s][m][2]) : r;
      b = 8'(tb[s][up[s][m][3]] >> (8 * up[s][m][2:1]));
      check("region", reg_o, m[7:0]);
      check("fault", flt, !ok);
      check("attr", attr, b);
      check("device", dev, b[7:4] == 4'h0);
      check("share", shr, (b[7:4] == 4'h0 || lo[s][m][4:3] == 2'h1) ?
        2'h0 : lo[s][m][4:3]);
      if (!ok) st[0] = 1'b1;
      if (!ok) fq.push_back(a);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1000000;
    n_fail++;
    conclude();
  end
  initial begin
    int i;
    logic [31:0] r, d;
    n_fail = 0;
    tests_run = 0;
    rst_n = 1'b0;
    {wr, rd, sec, cv, cw, cf, cp, cs} = 8'h00;
    addr = 8'h00;
    wd = 32'h0;
    ca = 32'h0;
    lo = '{default: 32'h0};
    up = '{default: 32'h0};
    tb = '{default: 32'h0};
    sl = '{default: 8'h00};
    {st, mk} = 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 32; i++) bus(1'b0, 8'(4 * (i >> 1)), 32'h0, i[0]);
    repeat (700) begin
      r = $random(seed);
      d = $random(seed);
      if (d[20]) d = d & 32'h00000FFF;
      case (r[2:0])
        3'h0: bus(1'b1, 8'h00, {28'h0, r[11:8]}, r[16]);
        3'h1: bus(1'b1, 8'(4 + 4 * r[6:4]), d, r[16]);
        3'h2: bus(1'b1, r[3] ? 8'h28 : 8'h24,
          r[5] ? d & 32'h0FFF0FFF : d, r[16]);
        3'h3: bus(1'b0, 8'(4 * r[7:4]), 32'h0, r[16]);
        3'h4: bus(1'b1, r[3] ? 8'h30 : 8'h2C, d, r[16]);
        default: chk(d & 32'h00000FFF, r[3], r[4], r[5], r[16]);
      endcase
      check("irq", irq, |(st & mk));
    end
    conclude();
  end
endmodule
